// File: pkg/acp_pkg.sv
// Purpose: Constants shared by the configuration port files
// Assumes: 13-bit register addresses, 8-bit register words
// Notes:   Offsets, field positions, reset values and counts
package acp_pkg;
    localparam logic [12:0] OFS_PORT_CFG   = 13'h000;
    localparam logic [12:0] OFS_CHIP_ID    = 13'h001;
    localparam logic [12:0] OFS_GRADE      = 13'h002;
    localparam logic [12:0] OFS_CHAN_SEL   = 13'h005;
    localparam logic [12:0] OFS_POWER      = 13'h008;
    localparam logic [12:0] OFS_CLOCK      = 13'h009;
    localparam logic [12:0] OFS_CLK_DIV    = 13'h00b;
    localparam logic [12:0] OFS_OUT_MODE   = 13'h014;
    localparam logic [12:0] OFS_TRANSFER   = 13'h0ff;

    localparam logic [7:0]  PORT_CFG_FIXED = 8'h18;
    localparam logic [7:0]  PORT_CFG_LSB   = 8'h42;
    localparam int          CFG_LSB_HI     = 6;
    localparam int          CFG_LSB_LO     = 1;
    localparam int          CFG_SOFT_HI    = 5;
    localparam int          CFG_SOFT_LO    = 2;

    localparam logic [7:0]  CHAN_SEL_RESET = 8'h33;
    localparam logic [7:0]  CHAN_SEL_MASK  = 8'h33;
    localparam int          NUM_LOCAL      = 4;
    localparam int          SEL_A          = 0;
    localparam int          SEL_B          = 1;
    localparam int          SEL_FCO        = 4;
    localparam int          SEL_DCO        = 5;

    localparam logic [1:0]  POWER_RESET    = 2'b00;
    localparam logic [1:0]  PM_FULL_DOWN   = 2'b01;
    localparam logic [2:0]  CLK_DIV_RESET  = 3'b000;
    localparam logic [7:0]  LOCAL_RESET    = 8'h00;
    localparam int          GRADE_LSB      = 4;

    localparam logic [1:0]  WL_ONE         = 2'b00;
    localparam logic [1:0]  WL_TWO         = 2'b01;
    localparam logic [1:0]  WL_THREE       = 2'b10;
    localparam logic [1:0]  WL_STREAM      = 2'b11;
    localparam logic [3:0]  INSTR_LAST     = 4'hf;
    localparam logic [3:0]  BYTE_LAST      = 4'h7;
    localparam logic [1:0]  STRAP_WAIT     = 2'h3;

    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_INSTR = 2'b01,
        PH_DATA  = 2'b11,
        PH_DONE  = 2'b10
    } acp_phase_t;
endpackage

// File: rtl/acp_sync.sv
// Purpose: Two-stage synchroniser for a group of pins
// Assumes: Inputs asynchronous to clock
// Notes:   First stage feeds the second stage only
`timescale 1ns/1ps
module acp_sync #(
    parameter int                WIDTH     = 3,
    parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clock) begin
                if (reset) begin
                    meta[i]     <= RESET_VAL[i];
                    sync_out[i] <= RESET_VAL[i];
                end else begin
                    meta[i]     <= async_in[i];
                    sync_out[i] <= meta[i];
                end
            end
        end
    endgenerate
endmodule // acp_sync

// File: rtl/acp_config_port.sv
// Purpose: Three-wire serial configuration port with register file
// Assumes: Serial clock far slower than CLOCK; mode 0 framing
// Notes:   Pin straps caught shortly after reset release
`timescale 1ns/1ps
// What this block does
// - Clock and select are inputs; data pin is input on writes, output on reads.
// - Select held high disables the port; clock and data activity ignored.
// - With port disabled, clock pin sets format and data pin sets power-down.
// - Pin functions come from levels strapped at power-on.
// - Register space holds chip config, index/transfer and global registers.
// - Reset loads critical registers with their defaults.
// - Channel select resets so writes reach both data and both clock channels.
// - Local registers have copies for A, B, data clock, frame clock.
// - Local write updates every copy whose select bit is set.
// - Local read with several selects set returns the first selected copy in order A, B, data clock, frame clock.
// - Global registers ignore channel select and apply device-wide.
// - Sixteen-bit instruction with address and length, then length-plus-one data bytes (length 11 streams until select rises).
// - First instruction bit selects read or write; read turns the data pin.
// - Eight-bit words, MSB first at power-up, LSB first selectable.
// - Soft-reset bit restores all user registers, then clears itself.
module acp_config_port
    import acp_pkg::*;
#(
    parameter logic [7:0] CHIP_ID  = 8'h5a,  // Arbitrary value
    parameter logic [2:0] GRADE_ID = 3'h0     // Arbitrary value
) (
    input  wire logic       CLOCK,
    input  wire logic       RESET,
    input  wire logic       SERIAL_CLOCK_FORMAT_PIN,
    input  wire logic       PORT_SELECT_N,
    input  wire logic       SERIAL_DATA_POWERDOWN_PIN_IN,
    output logic            SERIAL_DATA_POWERDOWN_PIN_OUT,
    output logic            SERIAL_DATA_POWERDOWN_PIN_OE,
    output logic            PORT_ENABLED,
    output logic            TWOS_COMPLEMENT,
    output logic            POWER_DOWN,
    output logic [1:0]      POWER_MODE,
    output logic            DUTY_CYCLE_STABILIZER,
    output logic [2:0]      CLOCK_DIVIDE,
    output logic [7:0]      LOCAL_CH_A,
    output logic [7:0]      LOCAL_CH_B,
    output logic [7:0]      LOCAL_DATA_CLOCK,
    output logic [7:0]      LOCAL_FRAME_CLOCK,
    output logic            TRANSFER_UPDATE
);
    logic [2:0]   pins_s;
    logic         sclk_s;
    logic         cs_n_s;
    logic         sdio_s;
    logic         sclk_d;
    logic         sclk_rise;
    logic         sclk_fall;
    logic [1:0]   strap_cnt;
    logic         strap_done;
    logic         strap_mode;
    logic         strap_fmt;
    logic         strap_pd;
    logic         port_en;
    acp_phase_t   phase;
    logic [3:0]   cnt;
    logic [14:0]  instr;
    logic         rw;
    logic [1:0]   wlen;
    logic [1:0]   bytes_left;
    logic [12:0]  addr;
    logic [7:0]   rx;
    logic [7:0]   tx;
    logic [15:0]  next_instr;
    logic [7:0]   next_rx;
    logic [12:0]  next_addr;
    logic         wr_stb;
    logic [12:0]  wr_addr;
    logic [7:0]   wr_data;
    logic         lsb_first;
    logic [7:0]   chan_sel;
    logic [1:0]   power_mode;
    logic         duty_cycle_stabilizer;
    logic [2:0]   clk_div;
    logic [7:0]   local_reg [NUM_LOCAL];

    function automatic int sel_bit(input int ch);
        case (ch)
            0:       return SEL_A;
            1:       return SEL_B;
            2:       return SEL_DCO;
            default: return SEL_FCO;
        endcase
    endfunction

    function automatic logic is_local(input logic [12:0] a);
        return a == OFS_OUT_MODE;
    endfunction

    function automatic logic [7:0] read_reg(input logic [12:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            OFS_PORT_CFG: v = PORT_CFG_FIXED | (lsb_first ? PORT_CFG_LSB : 8'h00);
            OFS_CHIP_ID:  v = CHIP_ID;
            OFS_GRADE:    v = {1'b0, GRADE_ID, 4'h0};
            OFS_CHAN_SEL: v = chan_sel;
            OFS_POWER:    v = {6'h00, power_mode};
            OFS_CLOCK:    v = {7'h00, duty_cycle_stabilizer};
            OFS_CLK_DIV:  v = {5'h00, clk_div};
            OFS_OUT_MODE: begin
                if (chan_sel[SEL_A])
                    v = local_reg[0];
                else if (chan_sel[SEL_B])
                    v = local_reg[1];
                else if (chan_sel[SEL_DCO])
                    v = local_reg[2];
                else
                    v = local_reg[3];
            end
            default:      v = 8'h00;
        endcase
        return v;
    endfunction

    acp_sync #(
        .WIDTH     (3),
        .RESET_VAL (3'b010)
    ) u_sync (
        .clock    (CLOCK),
        .reset    (RESET),
        .async_in ({SERIAL_CLOCK_FORMAT_PIN, PORT_SELECT_N, SERIAL_DATA_POWERDOWN_PIN_IN}),
        .sync_out (pins_s)
    );

    assign sclk_s    = pins_s[2];
    assign cs_n_s    = pins_s[1];
    assign sdio_s    = pins_s[0];
    assign sclk_rise = sclk_s && !sclk_d && !cs_n_s && port_en;
    assign sclk_fall = !sclk_s && sclk_d && !cs_n_s && port_en;
    assign port_en   = strap_done && !strap_mode;
    assign next_instr = {instr, sdio_s};
    assign next_rx   = lsb_first ? {sdio_s, rx[7:1]} : {rx[6:0], sdio_s};
    assign next_addr = lsb_first ? addr + 13'h001 : addr - 13'h001;

    always_ff @(posedge CLOCK) begin
        if (RESET)
            sclk_d <= 1'b0;
        else
            sclk_d <= sclk_s;
    end

    // Strap capture after synchroniser settles
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            strap_cnt  <= 2'h0;
            strap_done <= 1'b0;
            strap_mode <= 1'b0;
            strap_fmt  <= 1'b0;
            strap_pd   <= 1'b0;
        end else if (!strap_done) begin
            strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == STRAP_WAIT) begin
                strap_done <= 1'b1;
                strap_mode <= cs_n_s;
                strap_fmt  <= sclk_s;
                strap_pd   <= sdio_s;
            end
        end
    end

    // Frame sequencing
    always_ff @(posedge CLOCK) begin
        if (RESET || cs_n_s || !port_en) begin
            phase      <= PH_IDLE;
            cnt        <= 4'h0;
            instr      <= 15'h0000;
            rw         <= 1'b0;
            wlen       <= WL_ONE;
            bytes_left <= 2'h0;
            addr       <= 13'h0000;
            rx         <= 8'h00;
            tx         <= 8'h00;
            wr_stb     <= 1'b0;
            wr_addr    <= 13'h0000;
            wr_data    <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            case (phase)
                PH_IDLE: begin
                    phase <= PH_INSTR;
                end
                PH_INSTR: begin
                    if (sclk_rise) begin
                        instr <= next_instr[14:0];
                        cnt   <= cnt + 4'h1;
                        if (cnt == INSTR_LAST) begin
                            phase      <= PH_DATA;
                            cnt        <= 4'h0;
                            rw         <= next_instr[15];
                            wlen       <= next_instr[14:13];
                            bytes_left <= next_instr[14:13];
                            addr       <= next_instr[12:0];
                            tx         <= read_reg(next_instr[12:0]);
                        end
                    end
                end
                PH_DATA: begin
                    if (sclk_rise) begin
                        rx  <= next_rx;
                        cnt <= cnt + 4'h1;
                        if (cnt == BYTE_LAST) begin
                            cnt     <= 4'h0;
                            wr_stb  <= !rw;
                            wr_addr <= addr;
                            wr_data <= next_rx;
                            addr    <= next_addr;
                            tx      <= read_reg(next_addr);
                            if (wlen != WL_STREAM) begin
                                bytes_left <= bytes_left - 2'h1;
                                if (bytes_left == 2'h0)
                                    phase <= PH_DONE;
                            end
                        end
                    end
                end
                PH_DONE: begin
                    phase <= PH_DONE;
                end
                default: begin
                    phase <= PH_IDLE;
                end
            endcase
        end
    end

    // Data pin turnaround on reads
    always_ff @(posedge CLOCK) begin
        if (RESET || cs_n_s || !port_en) begin
            SERIAL_DATA_POWERDOWN_PIN_OE  <= 1'b0;
            SERIAL_DATA_POWERDOWN_PIN_OUT <= 1'b0;
        end else begin
            SERIAL_DATA_POWERDOWN_PIN_OE <= (phase == PH_DATA) && rw;
            if (sclk_fall && phase == PH_DATA && rw)
                SERIAL_DATA_POWERDOWN_PIN_OUT <= lsb_first ? tx[cnt[2:0]] : tx[3'h7 - cnt[2:0]];
        end
    end

    // Register file
    always_ff @(posedge CLOCK) begin
        if (RESET || (wr_stb && wr_addr == OFS_PORT_CFG
                      && (wr_data[CFG_SOFT_HI] || wr_data[CFG_SOFT_LO]))) begin
            lsb_first  <= 1'b0;
            chan_sel   <= CHAN_SEL_RESET;
            power_mode <= POWER_RESET;
            duty_cycle_stabilizer        <= 1'b0;
            clk_div    <= CLK_DIV_RESET;
            for (int i = 0; i < NUM_LOCAL; i++)
                local_reg[i] <= LOCAL_RESET;
        end else if (wr_stb) begin
            case (wr_addr)
                OFS_PORT_CFG: lsb_first  <= wr_data[CFG_LSB_HI] || wr_data[CFG_LSB_LO];
                OFS_CHAN_SEL: chan_sel   <= wr_data & CHAN_SEL_MASK;
                OFS_POWER:    power_mode <= wr_data[1:0];
                OFS_CLOCK:    duty_cycle_stabilizer        <= wr_data[0];
                OFS_CLK_DIV:  clk_div    <= wr_data[2:0];
                default:      lsb_first  <= lsb_first;
            endcase
            if (is_local(wr_addr)) begin
                for (int i = 0; i < NUM_LOCAL; i++)
                    if (chan_sel[sel_bit(i)])
                        local_reg[i] <= wr_data;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET)
            TRANSFER_UPDATE <= 1'b0;
        else
            TRANSFER_UPDATE <= wr_stb && wr_addr == OFS_TRANSFER && wr_data[0];
    end

    assign PORT_ENABLED          = port_en;
    assign TWOS_COMPLEMENT       = strap_mode ? strap_fmt : local_reg[0][0];
    assign POWER_DOWN            = strap_mode ? strap_pd : (power_mode == PM_FULL_DOWN);
    assign POWER_MODE            = power_mode;
    assign DUTY_CYCLE_STABILIZER = duty_cycle_stabilizer;
    assign CLOCK_DIVIDE          = clk_div;
    assign LOCAL_CH_A            = local_reg[0];
    assign LOCAL_CH_B            = local_reg[1];
    assign LOCAL_DATA_CLOCK      = local_reg[2];
    assign LOCAL_FRAME_CLOCK     = local_reg[3];

    chk_strap_quiet: assert property (@(posedge CLOCK) disable iff (RESET)
        strap_mode |-> !SERIAL_DATA_POWERDOWN_PIN_OE && phase == PH_IDLE)
        else $error("port active while strapped off");
    chk_drive_read: assert property (@(posedge CLOCK) disable iff (RESET)
        SERIAL_DATA_POWERDOWN_PIN_OE |-> rw && !wr_stb)
        else $error("data pin driven outside a read");
    chk_chsel_reset: assert property (@(posedge CLOCK)
        RESET |=> chan_sel == CHAN_SEL_RESET && power_mode == POWER_RESET)
        else $error("channel select not at default");
    chk_local_copy: assert property (@(posedge CLOCK) disable iff (RESET)
        wr_stb && is_local(wr_addr) && chan_sel[SEL_B] |=> local_reg[1] == $past(wr_data))
        else $error("selected local copy missed the write");
    chk_read_chan_a: assert property (@(posedge CLOCK) disable iff (RESET)
        phase == PH_INSTR && sclk_rise && cnt == INSTR_LAST && next_instr[15]
        && next_instr[12:0] == OFS_OUT_MODE && chan_sel[SEL_A] |=> tx == local_reg[0])
        else $error("local read not from channel A");
    chk_global_write: assert property (@(posedge CLOCK) disable iff (RESET)
        wr_stb && wr_addr == OFS_CLOCK |=> duty_cycle_stabilizer == $past(wr_data[0]))
        else $error("global write lost");
    chk_soft_reset: assert property (@(posedge CLOCK) disable iff (RESET)
        wr_stb && wr_addr == OFS_PORT_CFG && wr_data[CFG_SOFT_HI]
        |=> chan_sel == CHAN_SEL_RESET && !lsb_first && read_reg(OFS_PORT_CFG) == PORT_CFG_FIXED)
        else $error("soft reset incomplete");
    chk_instr_len: assert property (@(posedge CLOCK) disable iff (RESET)
        phase == PH_INSTR && sclk_rise && cnt == INSTR_LAST |=> phase == PH_DATA && cnt == 4'h0)
        else $error("instruction phase length wrong");
    chk_unmapped_zero: assert property (@(posedge CLOCK) disable iff (RESET)
        phase == PH_DATA && rw && (addr == 13'h013 || addr == 13'h00a) |-> tx == 8'h00)
        else $error("unmapped address reads nonzero");
endmodule // acp_config_port

// File: tb/acp_spi_master.sv
// Purpose: Serial master model for the three-wire port
// Assumes: Mode 0 framing, half period of four system clocks
// Notes:   Released data line toggles every cycle
`timescale 1ns/1ps
module acp_spi_master (
    input  wire logic clock,
    input  wire logic dev_out,
    input  wire logic dev_oe,
    output logic      sclk,
    output logic      cs_n,
    output wire logic data_line
);
    logic m_oe;
    logic m_dat;
    logic last;
    logic lsb_first;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b0;
        m_oe = 1'b1;
        m_dat = 1'b0;
        last = 1'b0;
        lsb_first = 1'b0;
    end

    // Wire level from both drivers
    assign data_line = dev_oe ? dev_out : (m_oe ? m_dat : ~last);

    always @(posedge clock) begin
        last <= data_line;
    end

    task automatic pins(input logic c, input logic s, input logic d);
        @(posedge clock);
        cs_n <= c;
        sclk <= s;
        m_dat <= d;
        m_oe <= 1'b1;
    endtask

    // One bit: data set at fall, sampled at rise, released after rise
    task automatic bitx(input logic d, input logic drive, input logic keep, output logic q);
        m_oe <= drive;
        m_dat <= d;
        repeat (4) @(posedge clock);
        sclk <= 1'b1;
        q = data_line;
        repeat (2) @(posedge clock);
        m_oe <= keep;
        repeat (2) @(posedge clock);
        sclk <= 1'b0;
    endtask

    task automatic xfer(input logic rd, input logic [1:0] wl, input logic [12:0] addr,
                        input logic [23:0] wd, output logic [23:0] rdv);
        logic [15:0] ins;
        logic [7:0]  b;
        logic        q;
        int          n;
        int          p;
        ins = {rd, wl, addr};
        n = int'(wl) + 1;
        rdv = '0;
        b = '0;
        @(posedge clock);
        cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--)
            bitx(ins[i], 1'b1, (i > 0) || !rd, q);
        for (int k = 0; k < n; k++) begin
            for (int i = 0; i < 8; i++) begin
                p = lsb_first ? i : 7 - i;
                bitx(wd[8 * (n - 1 - k) + p], !rd, !rd, q);
                b[p] = q;
            end
            rdv = {rdv[15:0], b};
        end
        repeat (4) @(posedge clock);
        cs_n <= 1'b1;
        repeat (8) @(posedge clock);
        m_oe <= 1'b1;
        repeat (4) @(posedge clock);
    endtask
endmodule // acp_spi_master

// File: tb/test_adc_spi_config_port.sv
// Purpose: Self-checking bench for the serial configuration port
// Assumes: Master model drives the pins on system clock edges
// Notes:   Fixed seed, random register values among corner cases
`timescale 1ns/1ps
module test_adc_spi_config_port;
    import acp_pkg::*;
    localparam logic [7:0] TB_CHIP_ID = 8'h3c;  // Arbitrary value
    localparam logic [2:0] TB_GRADE   = 3'h5;   // Arbitrary value
    localparam logic [12:0] RA [6] = '{13'h000, 13'h001, 13'h002, 13'h005, 13'h013, 13'h0ff};
    localparam logic [7:0]  RE [6] = '{8'h18, TB_CHIP_ID, {1'b0, TB_GRADE, 4'h0}, 8'h33, 8'h00, 8'h00};
    localparam logic [7:0]  SELS [6] = '{8'h33, 8'h10, 8'h20, 8'h02, 8'h13, 8'h01};
    logic        clock;
    logic        reset;
    wire  logic  sck;
    wire  logic  csn;
    wire  logic  sdio;
    logic        dout;
    logic        doe;
    logic        en;
    logic        twos;
    logic        pdn;
    logic [1:0]  pm;
    logic        duty_cycle_stabilizer;
    logic [2:0]  cdiv;
    logic [7:0]  la, lb, ld, lf;
    logic        upd;
    logic [7:0]  ea, eb, ed, ef;
    logic [7:0]  v;
    logic [2:0]  c;
    logic [23:0] r;
    int          n_fail, checks_done, n_pulse, n_clash, cycles;

    acp_config_port #(.CHIP_ID(TB_CHIP_ID), .GRADE_ID(TB_GRADE)) uut (
        .CLOCK(clock), .RESET(reset), .SERIAL_CLOCK_FORMAT_PIN(sck), .PORT_SELECT_N(csn),
        .SERIAL_DATA_POWERDOWN_PIN_IN(sdio), .SERIAL_DATA_POWERDOWN_PIN_OUT(dout),
        .SERIAL_DATA_POWERDOWN_PIN_OE(doe), .PORT_ENABLED(en), .TWOS_COMPLEMENT(twos),
        .POWER_DOWN(pdn), .POWER_MODE(pm), .DUTY_CYCLE_STABILIZER(duty_cycle_stabilizer), .CLOCK_DIVIDE(cdiv),
        .LOCAL_CH_A(la), .LOCAL_CH_B(lb), .LOCAL_DATA_CLOCK(ld), .LOCAL_FRAME_CLOCK(lf),
        .TRANSFER_UPDATE(upd));

    acp_spi_master bfm (.clock(clock), .dev_out(dout), .dev_oe(doe), .sclk(sck), .cs_n(csn),
                        .data_line(sdio));

    always #12.5 clock = ~clock;

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Pulse count, drive clash watch and timeout
    always @(posedge clock) begin
        cycles++;
        if (upd === 1'b1) n_pulse++;
        if (doe === 1'b1 && bfm.m_oe === 1'b1) n_clash++;
        if (cycles == 60000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        bfm.xfer(1'b0, WL_ONE, a, {16'h0, d}, r);
    endtask

    task automatic rd(input logic [12:0] a, input logic [7:0] e);
        bfm.xfer(1'b1, WL_ONE, a, 24'h0, r);
        chk("read data", r[7:0], e);
    endtask

    function automatic void apply(input logic [7:0] s, input logic [7:0] d);
        if (s[SEL_A]) ea = d;
        if (s[SEL_B]) eb = d;
        if (s[SEL_DCO]) ed = d;
        if (s[SEL_FCO]) ef = d;
    endfunction

    task automatic chk_locals();
        chk("local a", la, ea);
        chk("local b", lb, eb);
        chk("local dco", ld, ed);
        chk("local fco", lf, ef);
    endtask

    task automatic do_reset(input logic cs, input logic s, input logic d);
        bfm.pins(cs, s, d);
        reset <= 1'b1;
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        repeat (16) @(posedge clock);
        {ea, eb, ed, ef} = '0;
    endtask

    initial begin
        clock = 1'b0;
        reset = 1'b1;
        void'($urandom(32'h130f8f12));
        do_reset(1'b0, 1'b0, 1'b0);
        bfm.pins(1'b1, 1'b0, 1'b0);
        repeat (10) @(posedge clock);
        chk("port enabled", {7'h0, en}, 8'h01);
        chk_locals();
        chk("power mode", {6'h0, pm}, {6'h0, POWER_RESET});
        chk("clock divide", {5'h0, cdiv}, {5'h0, CLK_DIV_RESET});
        for (int i = 0; i < 6; i++) rd(RA[i], RE[i]);
        $display("test defaults done");
        for (int i = 0; i < 6; i++) begin
            v = {i[2:0], 5'($urandom)};
            wr(OFS_CHAN_SEL, SELS[i]);
            wr(OFS_OUT_MODE, v);
            apply(SELS[i], v);
            chk_locals();
        end
        chk("twos from local", {7'h0, twos}, {7'h0, ea[0]});
        wr(OFS_CHAN_SEL, 8'h02);
        rd(OFS_OUT_MODE, eb);
        wr(OFS_CHAN_SEL, 8'h33);
        rd(OFS_OUT_MODE, ea);
        wr(OFS_POWER, {6'h0, PM_FULL_DOWN});
        chk("power mode", {6'h0, pm}, {6'h0, PM_FULL_DOWN});
        chk("power down", {7'h0, pdn}, 8'h01);
        wr(OFS_CHAN_SEL, 8'h01);
        rd(OFS_POWER, {6'h0, PM_FULL_DOWN});
        $display("test locals done");
        bfm.xfer(1'b0, WL_TWO, OFS_CLOCK, 24'h000100, r);
        chk("stabilizer", {7'h0, duty_cycle_stabilizer}, 8'h01);
        chk("power mode", {6'h0, pm}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            c = 3'($urandom_range(4));
            wr(OFS_CLK_DIV, {5'h0, c});
            chk("clock divide", {5'h0, cdiv}, {5'h0, c});
        end
        bfm.xfer(1'b1, WL_THREE, OFS_CLK_DIV, 24'h0, r);
        chk("burst read", r[23:16], {5'h0, c});
        chk("burst read", r[15:8], 8'h00);
        chk("burst read", r[7:0], 8'h01);
        bfm.xfer(1'b1, WL_STREAM, OFS_CLK_DIV, 24'h0, r);
        chk("stream read", r[23:16], 8'h00);
        chk("stream read", r[15:8], 8'h01);
        chk("stream read", r[7:0], 8'h00);
        wr(OFS_CHIP_ID, 8'hff);
        rd(OFS_CHIP_ID, TB_CHIP_ID);
        n_pulse = 0;
        wr(OFS_TRANSFER, 8'h01);
        chk("update pulses", 8'(n_pulse), 8'h01);
        $display("test burst done");
        wr(OFS_PORT_CFG, PORT_CFG_LSB);
        bfm.lsb_first = 1'b1;
        rd(OFS_PORT_CFG, 8'h5a);
        wr(OFS_CLK_DIV, 8'h03);
        chk("clock divide", {5'h0, cdiv}, 8'h03);
        wr(OFS_PORT_CFG, 8'h24);
        bfm.lsb_first = 1'b0;
        {ea, eb, ed, ef} = '0;
        chk_locals();
        chk("clock divide", {5'h0, cdiv}, 8'h00);
        chk("stabilizer", {7'h0, duty_cycle_stabilizer}, 8'h00);
        rd(OFS_PORT_CFG, PORT_CFG_FIXED);
        rd(OFS_CHAN_SEL, CHAN_SEL_RESET);
        $display("test bit order done");
        for (int p = 0; p < 2; p++) begin
            do_reset(1'b1, p[0], !p[0]);
            repeat (10) @(posedge clock);
            for (int i = 0; i < 40; i++) bfm.pins(1'b1, i[1], i[2]);
            chk("port enabled", {7'h0, en}, 8'h00);
            chk("format strap", {7'h0, twos}, {7'h0, p[0]});
            chk("powerdown strap", {7'h0, pdn}, {7'h0, !p[0]});
            chk("data drive", {7'h0, doe}, 8'h00);
        end
        chk("drive clashes", 8'(n_clash), 8'h00);
        $display("test straps done");
        final_report();
    end
endmodule // test_adc_spi_config_port
